// >>> src/autoneg_advert_upper_words.sv
// Middle and upper base-page advertisement words behind a Clause 45 management slave.
// Assumes mdc and mdio are synchronous to clock and mdc is well below half its rate.
//
// Behaviour
// - Middle word at 0x0203 in device 0x07, reset value 0x4000.
// - Upper word at 0x0204 in device 0x07, reset value 0x0000.
// - Middle bit 14 is a writable long-reach ability flag, resetting to one.
// - Middle bit 4 is the writable role: zero slave, one master.
// - Advertised role goes to the partner as nonce bit 4.
// - Role is a preference or forced value per the role-forcing bit.
// - Upper bit 13 is a writable high-swing capability flag.
// - Upper bit 12 is a writable high-swing request flag.
// - Either end not high-swing capable gives the low 1.0 V amplitude.
// - Both capable and either requesting, with partner_valid high, gives the 2.4 V amplitude.
// - Low word bit 12 marks the role preferred (zero) or forced (one).
`timescale 1ns/1ns
module autoneg_advert_upper_words
	import autoneg_advert_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Management pins
	input  wire logic        mdc,
	input  wire logic        mdio_in,
	output logic             mdio_out,
	output logic             mdio_oe_n,
	input  wire logic [4:0]  phy_addr,
	// Strap pins
	input  wire strap_s      straps,
	// Autonegotiation engine
	input  wire logic        adv_role_forced,
	input  wire hs_s         partner_hs,
	input  wire logic        partner_valid,
	output logic [15:0]      advert_word_middle,
	output logic [15:0]      advert_word_upper,
	output logic             nonce_role,
	output logic             role_is_forced,
	output logic             tx_high_swing
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic is_read(input logic [1:0] op);
		is_read = (op == OP_READ) || (op == OP_RDINC);
	endfunction

	function automatic logic [15:0] rd_word(input logic [15:0] addr,
		input logic [15:0] mid, input logic [15:0] up);
		if (addr == ADDR_MIDDLE) begin
			rd_word = mid;
		end else if (addr == ADDR_UPPER) begin
			rd_word = up;
		end else begin
			rd_word = 16'h0000;
		end
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	mgmt_state_e state_q;
	mgmt_state_e state_d;
	logic        mdc_q;
	logic [5:0]  pre_cnt_q;
	logic [4:0]  bit_cnt_q;
	logic [12:0] hdr_q;
	logic [1:0]  op_q;
	logic        match_q;
	logic [15:0] data_q;
	logic [15:0] addr_q;
	logic [15:0] middle_q;
	logic [15:0] upper_q;
	logic        init_done_q;
	logic        out_q;
	logic        oe_n_q;
	logic        nonce_q;
	logic        forced_q;
	hs_s         local_hs;

	// ------------------------------------------------------------
	// Frame decode
	// ------------------------------------------------------------
	wire         mdc_rise   = mdc & ~mdc_q;
	wire [13:0]  hdr_full   = {hdr_q, mdio_in};
	wire [1:0]   hdr_st     = hdr_full[13:12];
	wire [1:0]   hdr_op     = hdr_full[11:10];
	wire [4:0]   hdr_prtad  = hdr_full[9:5];
	wire [4:0]   hdr_devad  = hdr_full[4:0];
	wire         in_pre     = state_q == ST_PRE;
	wire         in_hdr     = state_q == ST_HDR;
	wire         in_ta      = state_q == ST_TA;
	wire         in_data    = state_q == ST_DATA;
	wire         pre_full   = pre_cnt_q == PRE_LEN;
	wire         frame_go   = in_pre & mdc_rise & ~mdio_in & pre_full;
	wire         hdr_end    = in_hdr & mdc_rise & (bit_cnt_q == HDR_LAST);
	wire         hdr_ok     = (hdr_st == ST_CODE) & (hdr_prtad == phy_addr)
	                          & (hdr_devad == DEV_AN);
	wire         ta_end     = in_ta & mdc_rise & (bit_cnt_q == TA_LAST);
	wire         data_end   = in_data & mdc_rise & (bit_cnt_q == DATA_LAST);
	wire         rd_act     = match_q & is_read(op_q);
	wire [15:0]  wdata      = {data_q[14:0], mdio_in};
	wire         wr_fire    = data_end & match_q & (op_q == OP_WRITE);
	wire         wr_middle  = wr_fire & (addr_q == ADDR_MIDDLE);
	wire         wr_upper   = wr_fire & (addr_q == ADDR_UPPER);
	wire         shift_en   = mdc_rise & (in_data | ta_end);

	// ------------------------------------------------------------
	// Register next values
	// ------------------------------------------------------------
	wire [15:0] middle_strap = (MIDDLE_RST & ~ROLE_M) | ({16{straps.role}} & ROLE_M);
	wire [15:0] upper_strap  = (UPPER_RST & ~(HS_CAPABLE_M | HS_REQUEST_M))
	                           | ({16{straps.hs_capable}} & HS_CAPABLE_M)
	                           | ({16{straps.hs_request}} & HS_REQUEST_M);
	wire [15:0] middle_d     = !init_done_q ? middle_strap :
	                           wr_middle ? (wdata & MIDDLE_WR_M) :
	                           middle_q;
	wire [15:0] upper_d      = !init_done_q ? upper_strap :
	                           wr_upper ? (wdata & UPPER_WR_M) :
	                           upper_q;
	wire [15:0] addr_d       = (data_end & match_q & (op_q == OP_ADDR)) ? wdata :
	                           (data_end & match_q & (op_q == OP_RDINC)) ? addr_q + 16'h0001 :
	                           addr_q;
	wire [15:0] data_d       = (hdr_end & hdr_ok & is_read(hdr_op)) ?
	                           rd_word(addr_q, middle_q, upper_q) :
	                           shift_en ? wdata : data_q;

	// ------------------------------------------------------------
	// Frame sequencing
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_PRE: begin
				if (frame_go) state_d = ST_HDR;
			end
			ST_HDR: begin
				if (hdr_end) state_d = hdr_st == ST_CODE ? ST_TA : ST_PRE;
			end
			ST_TA: begin
				if (ta_end) state_d = ST_DATA;
			end
			ST_DATA: begin
				if (data_end) state_d = ST_PRE;
			end
			default: state_d = ST_PRE;
		endcase
	end

	wire [5:0] pre_cnt_d = !in_pre ? 6'h00 :
	                       !mdc_rise ? pre_cnt_q :
	                       !mdio_in ? 6'h00 :
	                       pre_full ? pre_cnt_q : pre_cnt_q + 6'h01;
	wire [4:0] bit_cnt_d = frame_go ? 5'h01 :
	                       (hdr_end | ta_end | data_end) ? 5'h00 :
	                       (mdc_rise & ~in_pre) ? bit_cnt_q + 5'h01 : bit_cnt_q;

	// Read drive: zero in the second turnaround bit, then data MSB first
	wire out_d  = (in_ta & mdc_rise & rd_act) ? ((bit_cnt_q == TA_LAST) & data_q[15]) :
	              (in_data & mdc_rise & rd_act) ? (~data_end & data_q[15]) : out_q;
	wire oe_n_d = (in_ta & mdc_rise & rd_act) ? 1'b0 :
	              (data_end | in_pre) ? 1'b1 : oe_n_q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= ST_PRE;
			mdc_q     <= 1'b0;
			pre_cnt_q <= 6'h00;
			bit_cnt_q <= 5'h00;
			hdr_q     <= 13'h0000;
			op_q      <= 2'h0;
			match_q   <= 1'b0;
			data_q    <= 16'h0000;
			addr_q    <= 16'h0000;
			out_q     <= 1'b0;
			oe_n_q    <= 1'b1;
		end else begin
			state_q   <= state_d;
			mdc_q     <= mdc;
			pre_cnt_q <= pre_cnt_d;
			bit_cnt_q <= bit_cnt_d;
			hdr_q     <= frame_go ? 13'h0000 : (in_hdr & mdc_rise) ? hdr_full[12:0] : hdr_q;
			op_q      <= hdr_end ? hdr_op : op_q;
			match_q   <= hdr_end ? hdr_ok : match_q;
			data_q    <= data_d;
			addr_q    <= addr_d;
			out_q     <= out_d;
			oe_n_q    <= oe_n_d;
		end
	end

	// ------------------------------------------------------------
	// Advertisement words and engine outputs
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			middle_q    <= MIDDLE_RST;
			upper_q     <= UPPER_RST;
			init_done_q <= 1'b0;
			nonce_q     <= 1'b0;
			forced_q    <= 1'b0;
		end else begin
			middle_q    <= middle_d;
			upper_q     <= upper_d;
			init_done_q <= 1'b1;
			nonce_q     <= middle_q[BIT_ROLE];
			forced_q    <= adv_role_forced;
		end
	end

	assign local_hs.capable = upper_q[BIT_HS_CAPABLE];
	assign local_hs.request = upper_q[BIT_HS_REQUEST];

	tx_level_resolver u_resolver (
		.clock         (clock),
		.rst_n         (rst_n),
		.local_hs      (local_hs),
		.partner_hs    (partner_hs),
		.partner_valid (partner_valid),
		.high_swing_q  (tx_high_swing)
	);

	assign mdio_out           = out_q;
	assign mdio_oe_n          = oe_n_q;
	assign advert_word_middle = middle_q;
	assign advert_word_upper  = upper_q;
	assign nonce_role         = nonce_q;
	assign role_is_forced     = forced_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence write_done_s;
		data_end && match_q && op_q == OP_WRITE;
	endsequence

	middle_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
		!init_done_q |-> middle_q == MIDDLE_RST)
		else $error("middle word not at reset value");

	upper_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
		!init_done_q |-> upper_q == UPPER_RST)
		else $error("upper word not at reset value");

	strap_load_a: assert property (@(posedge clock) disable iff (!rst_n)
		(init_done_q && !$past(init_done_q)) |-> middle_q[BIT_ROLE] == $past(straps.role)
		&& upper_q[BIT_HS_CAPABLE] == $past(straps.hs_capable)
		&& upper_q[BIT_HS_REQUEST] == $past(straps.hs_request)
		&& middle_q[BIT_LONG_REACH])
		else $error("strap values not loaded");

	middle_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		(write_done_s and (addr_q == ADDR_MIDDLE) and init_done_q)
		|=> middle_q == ($past(wdata) & MIDDLE_WR_M))
		else $error("middle word write lost");

	upper_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		(write_done_s and (addr_q == ADDR_UPPER) and init_done_q)
		|=> upper_q == ($past(wdata) & UPPER_WR_M))
		else $error("upper word write lost");

	reserved_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
		(middle_q & ~MIDDLE_WR_M) == 16'h0000 && (upper_q & ~UPPER_WR_M) == 16'h0000)
		else $error("reserved bit set");

	nonce_role_a: assert property (@(posedge clock) disable iff (!rst_n)
		$changed(middle_q[BIT_ROLE]) |=> nonce_q == $past(middle_q[BIT_ROLE]) ##1 $stable(nonce_q))
		else $error("nonce role bit does not follow role");

	role_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
		##1 forced_q == $past(adv_role_forced))
		else $error("role mode not passed on");

	read_drive_a: assert property (@(posedge clock) disable iff (!rst_n)
		(in_ta && mdc_rise && rd_act && bit_cnt_q == 5'h00) |=> !oe_n_q && !out_q)
		else $error("turnaround not driven low on read");

endmodule

// >>> src/autoneg_advert_pkg.sv
// Constants, types and field layouts for the autonegotiation advertisement words.
// Assumes a Clause 45 management frame arriving on synchronous mdc and mdio pins.
package autoneg_advert_pkg;

	// ------------------------------------------------------------
	// Management addressing
	// ------------------------------------------------------------
	localparam logic [4:0]  DEV_AN      = 5'h07;
	localparam logic [15:0] ADDR_MIDDLE = 16'h0203;
	localparam logic [15:0] ADDR_UPPER  = 16'h0204;

	// ------------------------------------------------------------
	// Register reset values and writable bits
	// ------------------------------------------------------------
	localparam logic [15:0] MIDDLE_RST  = 16'h4000;
	localparam logic [15:0] UPPER_RST   = 16'h0000;
	localparam logic [15:0] MIDDLE_WR_M = 16'h4010;
	localparam logic [15:0] UPPER_WR_M  = 16'h3000;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int          BIT_LONG_REACH = 14;
	localparam int          BIT_ROLE       = 4;
	localparam int          BIT_HS_CAPABLE = 13;
	localparam int          BIT_HS_REQUEST = 12;
	localparam logic [15:0] ROLE_M         = 16'h0010;
	localparam logic [15:0] HS_CAPABLE_M   = 16'h2000;
	localparam logic [15:0] HS_REQUEST_M   = 16'h1000;

	// ------------------------------------------------------------
	// Frame timing in mdc bits
	// ------------------------------------------------------------
	localparam logic [5:0] PRE_LEN   = 6'h20;
	localparam logic [4:0] HDR_LAST  = 5'h0D;
	localparam logic [4:0] TA_LAST   = 5'h01;
	localparam logic [4:0] DATA_LAST = 5'h0F;

	// ------------------------------------------------------------
	// Frame codes
	// ------------------------------------------------------------
	localparam logic [1:0] ST_CODE  = 2'h0;
	localparam logic [1:0] OP_ADDR  = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_RDINC = 2'h2;
	localparam logic [1:0] OP_READ  = 2'h3;

	typedef enum logic [3:0] {
		ST_PRE  = 4'b0001,
		ST_HDR  = 4'b0010,
		ST_TA   = 4'b0100,
		ST_DATA = 4'b1000
	} mgmt_state_e;

	typedef struct packed {
		logic role;
		logic hs_capable;
		logic hs_request;
	} strap_s;

	typedef struct packed {
		logic capable;
		logic request;
	} hs_s;

endpackage

// >>> src/tx_level_resolver.sv
// Resolves the transmit amplitude from both ends' high-swing bits.
// Assumes partner bits are stable while partner_valid is high.
`timescale 1ns/1ns
module tx_level_resolver
	import autoneg_advert_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// Ability bits of both ends
	input  wire hs_s  local_hs,
	input  wire hs_s  partner_hs,
	input  wire logic partner_valid,
	// Resolved level, high means 2.4 V p-p
	output logic      high_swing_q
);

	wire both_capable = local_hs.capable & partner_hs.capable;
	wire any_request  = local_hs.request | partner_hs.request;
	wire high_d       = partner_valid & both_capable & any_request;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			high_swing_q <= 1'b0;
		end else begin
			high_swing_q <= high_d;
		end
	end

	low_swing_a: assert property (@(posedge clock) disable iff (!rst_n)
		!both_capable |=> !high_swing_q)
		else $error("high swing chosen without both ends capable");

	high_swing_a: assert property (@(posedge clock) disable iff (!rst_n)
		(partner_valid && both_capable && any_request) |=> high_swing_q)
		else $error("high swing not chosen though capable and requested");

endmodule

// >>> tb/mdio_host.sv
// Station manager model that sends Clause 45 frames on mdc and mdio.
// Assumes the device samples mdc on clock; the shared line has a pull-up.
`timescale 1ns/1ns
module mdio_host (
	// Clock
	input  wire logic clock,
	// Device side of the pin
	input  wire logic mdio_out,
	input  wire logic mdio_oe_n,
	// Host side
	output logic      mdc,
	output logic      mdio_in
);
	localparam logic [1:0] ST_CODE_H = 2'h0;

	logic host_en;
	logic host_val;

	// Line level from both drivers, pull-up when neither drives
	assign mdio_in = !mdio_oe_n ? mdio_out : (host_en ? host_val : 1'b1);

	initial begin
		mdc      = 1'b0;
		host_en  = 1'b0;
		host_val = 1'b1;
	end

	// One bit: low phase two clocks, sample before the rise, high phase two clocks
	task automatic bit_io(input logic en, input logic b, output logic r);
		@(posedge clock);
		mdc      <= 1'b0;
		host_en  <= en;
		host_val <= b;
		@(posedge clock);
		@(posedge clock);
		r = mdio_in;
		mdc <= 1'b1;
		@(posedge clock);
	endtask

	task automatic frame(input logic [1:0] op, input logic [4:0] prt, input logic [4:0] dev,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [13:0] hdr;
		logic        r;
		logic        drv;
		hdr = {ST_CODE_H, op, prt, dev};
		drv = !op[1];
		for (int i = 0; i < 32; i++) bit_io(1'b1, 1'b1, r);
		for (int i = 13; i >= 0; i--) bit_io(1'b1, hdr[i], r);
		bit_io(drv, 1'b1, r);
		bit_io(drv, 1'b0, r);
		for (int i = 15; i >= 0; i--) begin
			bit_io(drv, wd[i], r);
			rd[i] = r;
		end
	endtask
endmodule

// >>> tb/autoneg_advert_upper_words_tb.sv
// Self-checking bench for the advertisement words and level resolution.
// Assumes the mdio_host model for all management traffic.
`timescale 1ns/1ns
module autoneg_advert_upper_words_tb import autoneg_advert_pkg::*;;
	localparam logic [4:0] PA = 5'h05;
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wd;
		logic [15:0] exp;
	} row_s;

	logic        clock;
	logic        rst_n;
	logic        mdc;
	logic        mdio_in;
	logic        mdio_out;
	logic        mdio_oe_n;
	strap_s      straps;
	logic        adv_role_forced;
	hs_s         partner_hs;
	logic        partner_valid;
	logic [15:0] advert_word_middle;
	logic [15:0] advert_word_upper;
	logic        nonce_role;
	logic        role_is_forced;
	logic        tx_high_swing;
	logic [15:0] v;
	logic        e;
	int          n_errors;
	int          comparisons;
	row_s        rows [6];

	autoneg_advert_upper_words uut (.clock(clock), .rst_n(rst_n), .mdc(mdc),
		.mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_addr(PA),
		.straps(straps), .adv_role_forced(adv_role_forced), .partner_hs(partner_hs),
		.partner_valid(partner_valid), .advert_word_middle(advert_word_middle),
		.advert_word_upper(advert_word_upper), .nonce_role(nonce_role),
		.role_is_forced(role_is_forced), .tx_high_swing(tx_high_swing));

	mdio_host u_host (.clock(clock), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
		.mdc(mdc), .mdio_in(mdio_in));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// ------------------------------------------------------------
	// Checks and bus helpers
	// ------------------------------------------------------------
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		logic [15:0] x;
		u_host.frame(OP_ADDR, PA, DEV_AN, a, x);
		u_host.frame(OP_WRITE, PA, DEV_AN, d, x);
		@(posedge clock);
	endtask

	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		logic [15:0] x;
		u_host.frame(OP_ADDR, PA, DEV_AN, a, x);
		u_host.frame(OP_READ, PA, DEV_AN, 16'h0000, d);
	endtask

	task automatic do_reset(input strap_s s);
		rst_n  <= 1'b0;
		straps <= s;
		repeat (10) @(posedge clock);
		chk16(advert_word_middle, MIDDLE_RST, "middle in reset");
		chk16(advert_word_upper, UPPER_RST, "upper in reset");
		chk1(mdio_oe_n, 1'b1, "mdio released in reset");
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		chk16(advert_word_middle, MIDDLE_RST | (s.role ? ROLE_M : 16'h0000), "strap mid");
		chk16(advert_word_upper, {2'b00, s.hs_capable, s.hs_request, 12'h000}, "strap up");
		chk1(nonce_role, s.role, "nonce after reset");
	endtask

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge clock);
		n_errors++;
		$display("[FAIL] %0t run did not finish in time", $time);
		wrap_up;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst_n           = 1'b0;
		straps          = 3'b110;
		adv_role_forced = 1'b0;
		partner_hs      = 2'b00;
		partner_valid   = 1'b0;
		rows = '{'{ADDR_MIDDLE, 16'hFFFF, 16'h4010}, '{ADDR_MIDDLE, 16'h0000, 16'h0000},
			'{ADDR_UPPER, 16'hFFFF, 16'h3000}, '{ADDR_UPPER, 16'h1000, 16'h1000},
			'{16'h0205, 16'hFFFF, 16'h0000}, '{ADDR_UPPER, 16'h2000, 16'h2000}};
		do_reset(3'b110);
		for (int i = 0; i < 6; i++) begin
			wr(rows[i].addr, rows[i].wd);
			rd(rows[i].addr, v);
			chk16(v, rows[i].exp, "readback");
			if (rows[i].addr === ADDR_MIDDLE) begin
				chk16(advert_word_middle, rows[i].exp, "middle out");
				chk1(nonce_role, rows[i].exp[BIT_ROLE], "nonce role");
			end
			if (rows[i].addr === ADDR_UPPER) chk16(advert_word_upper, rows[i].exp, "upper");
		end
		for (int l = 0; l < 4; l++) begin
			wr(ADDR_UPPER, {2'b00, 2'(l), 12'h000});
			chk1(advert_word_upper[BIT_HS_CAPABLE], l[1], "capable bit");
			for (int p = 0; p < 4; p++) begin
				@(posedge clock);
				partner_hs    <= 2'(p);
				partner_valid <= 1'b1;
				repeat (3) @(posedge clock);
				e = l[1] & p[1] & (l[0] | p[0]);
				if (l[1] & p[1]) chk1(tx_high_swing, e, "high level");
				else chk1(tx_high_swing, e, "low level");
			end
		end
		partner_valid <= 1'b0;
		repeat (3) @(posedge clock);
		chk1(tx_high_swing, 1'b0, "no partner low level");
		adv_role_forced <= 1'b1;
		repeat (3) @(posedge clock);
		chk1(role_is_forced, 1'b1, "forced role");
		adv_role_forced <= 1'b0;
		repeat (3) @(posedge clock);
		chk1(role_is_forced, 1'b0, "preferred role");
		u_host.frame(OP_ADDR, PA ^ 5'h01, DEV_AN, ADDR_MIDDLE, v);
		u_host.frame(OP_WRITE, PA ^ 5'h01, DEV_AN, 16'hFFFF, v);
		u_host.frame(OP_WRITE, PA, 5'h01, 16'hFFFF, v);
		u_host.frame(OP_READ, PA ^ 5'h01, DEV_AN, 16'h0000, v);
		chk16(v, 16'hFFFF, "foreign read undriven");
		chk16(advert_word_middle, 16'h0000, "foreign write");
		u_host.frame(OP_ADDR, PA, DEV_AN, ADDR_MIDDLE, v);
		u_host.frame(OP_RDINC, PA, DEV_AN, 16'h0000, v);
		chk16(v, 16'h0000, "read then step");
		u_host.frame(OP_READ, PA, DEV_AN, 16'h0000, v);
		chk16(v, 16'h3000, "stepped read");
		do_reset(3'b001);
		wrap_up;
	end
endmodule
